//--- mbtcp_read_server.sv
/*
  Read request server: parses framed requests, checks them, and streams responses.
  Assumes a byte stream with valid/ready on both sides, one request at a time.
*/
module mbtcp_read_server
(
  input  wire logic                                                      i_clk_sys,
  input  wire logic                                                      i_sys_rst,
  input  wire logic [7:0]                                                i_unit_addr,
  input  wire logic                                                      i_rx_valid,
  input  wire logic [7:0]                                                i_rx_data,
  output logic                                                           o_rx_ready,
  output logic                                                           o_tx_valid,
  output logic [7:0]                                                     o_tx_data,
  output logic                                                           o_tx_last,
  input  wire logic                                                      i_tx_ready,
  output logic                                                           o_req_drop,
  input  wire logic [mbtcp_pkg::NODE_MAX*mbtcp_pkg::REGS_PER_NODE*16-1:0] i_regs,
  input  wire logic [mbtcp_pkg::NODE_MAX*mbtcp_pkg::COILS_PER_NODE-1:0]   i_coils,
  input  wire logic [mbtcp_pkg::NODE_MAX*mbtcp_pkg::INPUTS_PER_NODE-1:0]  i_inputs
);

  ////////////////////////////////////////////////////////////////////////////
  // Request capture

  mbtcp_pkg::srv_state_t state_ff;
  mbtcp_pkg::srv_state_t nxt_state;
  logic [7:0]  req_ff [12];
  logic [3:0]  rx_cnt_ff;
  logic [15:0] tx_cnt_ff;
  logic [7:0]  unit_cfg_ff;
  logic [7:0]  tx_data_ff;
  logic        drop_ff;

  mbtcp_data_if data_bus();

  wire logic rx_fire = i_rx_valid && o_rx_ready;
  wire logic tx_fire = o_tx_valid && i_tx_ready;

  assign o_rx_ready = (state_ff == mbtcp_pkg::ST_RX);

  wire logic [15:0] f_tid   = {req_ff[0], req_ff[1]};
  wire logic [7:0]  f_unit  = req_ff[6];
  wire logic [7:0]  f_fc    = req_ff[7];
  wire logic [15:0] f_start = {req_ff[8], req_ff[9]};
  wire logic [15:0] f_qty   = {req_ff[10], req_ff[11]};

  ////////////////////////////////////////////////////////////////////////////
  // Validity checks

  wire logic proto_ok = (req_ff[2] == mbtcp_pkg::FIXED_ZERO)
                     && (req_ff[3] == mbtcp_pkg::FIXED_ZERO);
  // Master owns the length; a read with any other length is not a read
  wire logic len_ok   = ({req_ff[4], req_ff[5]} == mbtcp_pkg::REQ_LEN_VALUE);
  wire logic unit_ok  = (f_unit >= mbtcp_pkg::UNIT_MIN) && (f_unit <= mbtcp_pkg::UNIT_MAX)
                     && (f_unit == unit_cfg_ff);
  // Zero quantity is refused as well as one over the limit
  function automatic logic qty_ok(input logic [15:0] qty, input logic [15:0] lim);
    qty_ok = (qty != 16'h0000) && (qty <= lim);
  endfunction

  wire logic inreg_ok = (f_fc == mbtcp_pkg::FC_INREGS)
                     && qty_ok(f_qty, mbtcp_pkg::INREG_MAX_QTY)
                     && (f_start >= mbtcp_pkg::INREG_BASE);
  wire logic coil_ok  = (f_fc == mbtcp_pkg::FC_COILS)
                     && qty_ok(f_qty, mbtcp_pkg::COIL_MAX_QTY);
  wire logic inp_ok   = (f_fc == mbtcp_pkg::FC_INPUTS)
                     && qty_ok(f_qty, mbtcp_pkg::INPUT_MAX_QTY);
  wire logic req_ok   = proto_ok && len_ok && unit_ok && (inreg_ok || coil_ok || inp_ok);

  ////////////////////////////////////////////////////////////////////////////
  // Response framing

  wire logic [15:0] bit_bytes = (f_qty + 16'h0007) >> 3;
  wire logic [15:0] pay_bytes = (f_fc == mbtcp_pkg::FC_INREGS) ? {f_qty[14:0], 1'b0}
                                                               : bit_bytes;
  wire logic [15:0] rsp_len   = pay_bytes + mbtcp_pkg::RSP_LEN_FIXED;
  wire logic [15:0] last_idx  = pay_bytes + 16'h0008;

  logic [7:0] hdr_byte;
  always_comb
  begin
    unique case (tx_cnt_ff[3:0])
      4'h0:    hdr_byte = f_tid[15:8];
      4'h1:    hdr_byte = f_tid[7:0];
      4'h2:    hdr_byte = mbtcp_pkg::FIXED_ZERO;
      4'h3:    hdr_byte = mbtcp_pkg::FIXED_ZERO;
      4'h4:    hdr_byte = rsp_len[15:8];
      4'h5:    hdr_byte = rsp_len[7:0];
      4'h6:    hdr_byte = f_unit;
      4'h7:    hdr_byte = f_fc;
      // Byte count is one byte: long register reads report only its low part
      default: hdr_byte = pay_bytes[7:0];
    endcase
  end

  assign data_bus.fc    = f_fc;
  assign data_bus.start = f_start;
  assign data_bus.idx   = tx_cnt_ff - 16'h0009;

  mbtcp_data_sel u_sel
  (
    .bus      (data_bus.sel),
    .i_regs   (i_regs),
    .i_coils  (i_coils),
    .i_inputs (i_inputs)
  );

  wire logic in_hdr = (tx_cnt_ff < 16'h0009);
  wire logic [7:0] nxt_tx_data = in_hdr ? hdr_byte : data_bus.byte_val;
  wire logic       rx_last     = rx_fire && (rx_cnt_ff == mbtcp_pkg::REQ_HDR_BYTES - 4'h1);
  wire logic [3:0] nxt_rx_cnt  = rx_last ? 4'h0 : rx_cnt_ff + 4'h1;
  wire logic       tx_load     = (state_ff == mbtcp_pkg::ST_HDR) || tx_fire;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      mbtcp_pkg::ST_RX:
        if (rx_last)
          nxt_state = mbtcp_pkg::ST_EVAL;
      mbtcp_pkg::ST_EVAL:
        nxt_state = req_ok ? mbtcp_pkg::ST_HDR : mbtcp_pkg::ST_RX;
      mbtcp_pkg::ST_HDR:
        nxt_state = mbtcp_pkg::ST_DATA;
      mbtcp_pkg::ST_DATA:
        // Leave only once the flagged final byte has been taken
        if (tx_fire && o_tx_last)
          nxt_state = mbtcp_pkg::ST_RX;
      default:
        nxt_state = mbtcp_pkg::ST_RX;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state_ff <= mbtcp_pkg::ST_RX;
    else
      state_ff <= nxt_state;
  end

  // One-cycle pulse: the request was judged and thrown away
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      drop_ff <= 1'b0;
    else
      drop_ff <= (state_ff == mbtcp_pkg::ST_EVAL) && !req_ok;
  end

  // Request bytes land in order; the counter wraps after the last one
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rx_cnt_ff <= 4'h0;
      for (int i = 0; i < 12; i++)
        req_ff[i] <= 8'h00;
    end
    else if (rx_fire)
    begin
      req_ff[rx_cnt_ff] <= i_rx_data;
      rx_cnt_ff         <= nxt_rx_cnt;
    end
  end

  // Cleared while judging, so a dropped request leaves no count behind
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tx_cnt_ff  <= mbtcp_pkg::CNT_RST;
      tx_data_ff <= 8'h00;
    end
    else if (state_ff == mbtcp_pkg::ST_EVAL)
      tx_cnt_ff <= mbtcp_pkg::CNT_RST;
    else if (tx_load)
    begin
      tx_data_ff <= nxt_tx_data;
      tx_cnt_ff  <= tx_cnt_ff + 16'h0001;
    end
  end

  // Unit address latched one cycle after reset release, then followed live
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      unit_cfg_ff <= mbtcp_pkg::UNIT_RST;
    else
      unit_cfg_ff <= i_unit_addr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // tx_cnt_ff points one past the byte currently presented
  assign o_tx_valid = (state_ff == mbtcp_pkg::ST_DATA);
  assign o_tx_data  = tx_data_ff;
  assign o_tx_last  = o_tx_valid && (tx_cnt_ff == last_idx + 16'h0001);
  assign o_req_drop = drop_ff;

endmodule

//--- mbtcp_pkg.sv
/*
  Shared constants and types for the read-only TCP request server.
  Assumes a byte stream of requests already stripped of TCP/IP framing.
*/
package mbtcp_pkg;

  localparam logic [7:0]  FIXED_ZERO      = 8'h00;
  localparam logic [15:0] REQ_LEN_VALUE   = 16'h0006;
  localparam logic [7:0]  UNIT_MIN        = 8'h01;
  localparam logic [7:0]  UNIT_MAX        = 8'hf7;
  localparam logic [7:0]  UNIT_RST        = 8'h01;
  localparam logic [7:0]  FC_COILS        = 8'h01;
  localparam logic [7:0]  FC_INPUTS       = 8'h02;
  localparam logic [7:0]  FC_INREGS       = 8'h04;
  localparam logic [15:0] INREG_BASE      = 16'h9c40;
  localparam logic [15:0] INREG_MAX_QTY   = 16'h015e;
  localparam logic [15:0] COIL_MAX_QTY    = 16'h0064;
  localparam logic [15:0] INPUT_MAX_QTY   = 16'h00c8;
  localparam logic [3:0]  REQ_HDR_BYTES   = 4'hc;
  localparam logic [15:0] RSP_LEN_FIXED   = 16'h0003;
  localparam int          NODE_MAX        = 50;
  localparam int          REGS_PER_NODE   = 7;
  localparam int          COILS_PER_NODE  = 2;
  localparam int          INPUTS_PER_NODE = 4;
  localparam logic [15:0] CNT_RST         = 16'h0000;

  typedef enum logic [2:0]
  {
    ST_RX   = 3'b000,
    ST_EVAL = 3'b001,
    ST_HDR  = 3'b011,
    ST_DATA = 3'b010
  } srv_state_t;

endpackage

//--- mbtcp_data_if.sv
/*
  Data lookup carrier between the server and its data selector.
  Assumes both ends run on the same clock.
*/
interface mbtcp_data_if;
  logic [7:0]  fc;
  logic [15:0] start;
  logic [15:0] idx;
  logic [7:0]  byte_val;

  modport server
  (
    output fc,
    output start,
    output idx,
    input  byte_val
  );

  modport sel
  (
    input  fc,
    input  start,
    input  idx,
    output byte_val
  );
endinterface

//--- mbtcp_data_sel.sv
/*
  Picks the response data byte for a given payload index.
  Assumes node tables are flat vectors supplied from the top.
*/
module mbtcp_data_sel
(
  mbtcp_data_if.sel                                             bus,
  input  wire logic [mbtcp_pkg::NODE_MAX*mbtcp_pkg::REGS_PER_NODE*16-1:0] i_regs,
  input  wire logic [mbtcp_pkg::NODE_MAX*mbtcp_pkg::COILS_PER_NODE-1:0]   i_coils,
  input  wire logic [mbtcp_pkg::NODE_MAX*mbtcp_pkg::INPUTS_PER_NODE-1:0]  i_inputs
);

  localparam int NREG = mbtcp_pkg::NODE_MAX * mbtcp_pkg::REGS_PER_NODE;
  localparam int NCOI = mbtcp_pkg::NODE_MAX * mbtcp_pkg::COILS_PER_NODE;
  localparam int NINP = mbtcp_pkg::NODE_MAX * mbtcp_pkg::INPUTS_PER_NODE;

  // Bit address beyond the table reads as zero
  function automatic logic bit_at(input logic [255:0] vec, input int n, input int lim);
    bit_at = (n >= 0 && n < lim) ? vec[n[7:0]] : 1'b0;
  endfunction

  wire logic [15:0] reg_num = bus.start - mbtcp_pkg::INREG_BASE + {1'b0, bus.idx[15:1]};
  wire logic [15:0] reg_val = (reg_num < 16'(NREG)) ? i_regs[reg_num*16 +: 16] : 16'h0000;
  wire logic [7:0]  reg_byte = bus.idx[0] ? reg_val[7:0] : reg_val[15:8];

  logic [7:0] pack_byte;
  always_comb
  begin
    pack_byte = 8'h00;
    for (int b = 0; b < 8; b++)
    begin
      // First requested bit lands in bit 0 of the first byte
      if (bus.fc == mbtcp_pkg::FC_COILS)
        pack_byte[b] = bit_at({156'h0, i_coils}, int'(bus.start) + int'(bus.idx)*8 + b, NCOI);
      else
        pack_byte[b] = bit_at({56'h0, i_inputs}, int'(bus.start) + int'(bus.idx)*8 + b, NINP);
    end
  end

  assign bus.byte_val = (bus.fc == mbtcp_pkg::FC_INREGS) ? reg_byte : pack_byte;

endmodule

//--- mbtcp_read_server_checker.sv
/* Port checker for the read server.
   Assumes one clock and one request in flight. */
module mbtcp_read_server_checker
(
  input wire logic       i_clk_sys,
  input wire logic       i_sys_rst,
  input wire logic [7:0] i_unit_addr,
  input wire logic       i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic       o_rx_ready,
  input wire logic       o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic       o_tx_last,
  input wire logic       i_tx_ready,
  input wire logic       o_req_drop
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  logic [3:0] rx_cnt_ff;
  logic [9:0] tx_cnt_ff;
  logic [7:0] unit_ff;
  wire        rx_take = i_rx_valid && o_rx_ready;
  wire        tx_take = o_tx_valid && i_tx_ready;
  // Byte positions in request and reply
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    if (i_sys_rst)
      {rx_cnt_ff, tx_cnt_ff, unit_ff} <= 22'h000000;
    else
    begin
      if (rx_take) rx_cnt_ff <= (rx_cnt_ff == 4'hb) ? 4'h0 : rx_cnt_ff + 4'h1;
      if (rx_take && rx_cnt_ff == 4'h6) unit_ff <= i_rx_data;
      if (tx_take) tx_cnt_ff <= o_tx_last ? 10'h000 : tx_cnt_ff + 10'h001;
    end
  //////////////////////////////////////////////
  sequence s_last_req;
    rx_take && rx_cnt_ff == 4'hb;
  endsequence
  property p_answer;
    s_last_req |-> ##[1:3] (o_tx_valid || o_req_drop);
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_bad_unit;
    s_last_req ##0 (unit_ff != i_unit_addr) |-> ##[1:3] o_req_drop;
  endproperty
  a_bad_unit: assert property (p_bad_unit) else $error("foreign unit served");
  property p_quiet;
    o_req_drop |-> !o_tx_valid [*3];
  endproperty
  a_quiet: assert property (p_quiet) else $error("reply after drop");
  property p_pulse;
    o_req_drop |=> !o_req_drop;
  endproperty
  a_pulse: assert property (p_pulse) else $error("drop not a pulse");
  property p_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("reply byte not held");
  property p_zero;
    o_tx_valid && tx_cnt_ff inside {10'h002, 10'h003} |-> o_tx_data == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("fixed bytes not zero");
  property p_unit;
    o_tx_valid && tx_cnt_ff == 10'h006 |-> o_tx_data == unit_ff;
  endproperty
  a_unit: assert property (p_unit) else $error("unit not echoed");
  property p_reopen;
    tx_take && o_tx_last |=> o_rx_ready && !o_tx_valid;
  endproperty
  a_reopen: assert property (p_reopen) else $error("receive not reopened");
endmodule
bind mbtcp_read_server mbtcp_read_server_checker mbtcp_read_server_checker_inst
(.i_clk_sys, .i_sys_rst, .i_unit_addr, .i_rx_valid, .i_rx_data, .o_rx_ready, .o_tx_valid,
 .o_tx_data, .o_tx_last, .i_tx_ready, .o_req_drop);

//--- mbtcp_master_model.sv
/* Remote master: sends one read request, collects reply or drop.
   Assumes it runs on the server clock, driving just after edges. */
module mbtcp_master_model
(
  input  wire logic       i_clk,
  input  wire logic       i_rx_ready,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_last,
  input  wire logic       i_req_drop,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] tid = 16'h0000;
  logic [15:0] proto = 16'h0000;
  logic [15:0] len_fld = 16'h0006;
  logic [7:0]  rsp [$];
  logic        dropped, hung, done;
  int          n;
  initial {o_rx_valid, o_rx_data, o_tx_ready} = 10'h000;
  task automatic req(logic [7:0] fc, logic [15:0] st, qty, logic [7:0] unit, bit slow);
    logic [7:0] b [12];
    b = '{tid[15:8], tid[7:0], proto[15:8], proto[7:0],
          len_fld[15:8], len_fld[7:0], unit, fc,
          st[15:8], st[7:0], qty[15:8], qty[7:0]};
    {dropped, hung, done} = 3'h0;
    rsp.delete();
    for (int i = 0; i < 12; i++)
    begin
      {o_rx_valid, o_rx_data} = {1'b1, b[i]};
      for (n = 0; n < 64; n++)
      begin
        @(posedge i_clk);
        if (i_rx_ready) break;
      end
      hung |= n == 64;
      #1;
    end
    // Released data line must not look like a held byte
    o_rx_valid = 1'b0;
    o_rx_data = ~o_rx_data;
    tid++;
    for (n = 0; n < 3000 && !done; n++)
    begin
      o_tx_ready = !slow || n[0];
      @(posedge i_clk);
      if (i_tx_valid && o_tx_ready) rsp.push_back(i_tx_data);
      dropped |= i_req_drop;
      done = dropped || (i_tx_valid && o_tx_ready && i_tx_last);
      #1;
    end
    hung |= !done;
    o_tx_ready = 1'b0;
  endtask
endmodule

//--- tb_top.sv
/* Table-driven bench for the read server.
   Assumes the master model and the bound port checker. */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] fc; logic [15:0] st, qty; logic [7:0] unit, cfg; logic drop;} row_t;
  logic          i_clk_sys, i_sys_rst, i_rx_valid, o_rx_ready, o_tx_valid, o_tx_last;
  logic          i_tx_ready, o_req_drop;
  logic [7:0]    i_unit_addr, i_rx_data, o_tx_data, exp [$];
  logic [5599:0] i_regs;
  logic [99:0]   i_coils;
  logic [199:0]  i_inputs;
  logic [15:0]   len, t;
  int            num_errors = 0, tests_run = 0, n;
  row_t rows [14] = '{
    '{8'h04, 16'h9c63, 16'h0007, 8'h01, 8'h01, 1'b0},
    '{8'h04, 16'h9c40, 16'h015e, 8'h01, 8'h01, 1'b0},
    '{8'h04, 16'h9c40, 16'h015f, 8'h01, 8'h01, 1'b1},
    '{8'h01, 16'h0002, 16'h0064, 8'h01, 8'h01, 1'b0},
    '{8'h01, 16'h0000, 16'h0065, 8'h01, 8'h01, 1'b1},
    '{8'h02, 16'h0004, 16'h0008, 8'h01, 8'h01, 1'b0},
    '{8'h02, 16'h0000, 16'h00c8, 8'h01, 8'h01, 1'b0},
    '{8'h02, 16'h0000, 16'h00c9, 8'h01, 8'h01, 1'b1},
    '{8'h03, 16'h0000, 16'h0001, 8'h01, 8'h01, 1'b1},
    '{8'h04, 16'h9c40, 16'h0002, 8'h02, 8'h01, 1'b1},
    '{8'h04, 16'h9c40, 16'h0002, 8'h00, 8'h00, 1'b1},
    '{8'h01, 16'h0000, 16'h0000, 8'h01, 8'h01, 1'b1},
    '{8'h04, 16'h9c3f, 16'h0001, 8'h01, 8'h01, 1'b1},
    '{8'h04, 16'h9c40, 16'h0002, 8'hf7, 8'hf7, 1'b0}};
  mbtcp_read_server mbtcp_read_server_inst
  (
    .i_clk_sys, .i_sys_rst, .i_unit_addr, .i_rx_valid, .i_rx_data, .o_rx_ready, .o_tx_valid,
    .o_tx_data, .o_tx_last, .i_tx_ready, .o_req_drop, .i_regs, .i_coils, .i_inputs
  );
  mbtcp_master_model mbtcp_master_model_inst
  (
    .i_clk(i_clk_sys), .i_rx_ready(o_rx_ready), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
    .i_tx_last(o_tx_last), .i_req_drop(o_req_drop), .o_rx_valid(i_rx_valid),
    .o_rx_data(i_rx_data), .o_tx_ready(i_tx_ready)
  );
  //////////////////////////////////////////////
  task automatic check(logic [15:0] seen, logic [15:0] want);
    tests_run++;
    if (seen !== want)
    begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Bits past the node tables read as zero
  function automatic logic [7:0] dbyte(row_t w, int j);
    int a = (w.fc == 8'h04) ? 2 * (w.st - 16'h9c40) + j : w.st + 8 * j;
    logic [7:0] b;
    if (w.fc == 8'h04) return i_regs[8*(a^1) +: 8];
    for (int k = 0; k < 8; k++)
      b[k] = (w.fc == 8'h01) ? a + k < 100 && i_coils[a+k] : a + k < 200 && i_inputs[a+k];
    return b;
  endfunction
  //////////////////////////////////////////////
  initial
  begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  initial
  begin
    i_sys_rst = 1'b1;
    i_unit_addr = 8'h01;
    for (int k = 0; k < 350; k++) i_regs[16*k +: 16] = 16'(k * 37 + 16'h1234);
    for (int k = 0; k < 100; k++) i_coils[k] = k[0] ^ k[2];
    for (int k = 0; k < 200; k++) i_inputs[k] = k % 3 == 0;
    repeat (2) @(posedge i_clk_sys);
    #1;
    check({o_rx_ready, o_tx_valid, o_tx_last, o_req_drop}, 16'h0008);
    i_sys_rst = 1'b0;
    foreach (rows[r])
    begin
      i_unit_addr = rows[r].cfg;
      repeat (2) @(posedge i_clk_sys);
      #1;
      t = mbtcp_master_model_inst.tid;
      n = (rows[r].fc == 8'h04) ? 2 * rows[r].qty : (rows[r].qty + 7) / 8;
      len = 16'(n + 3);
      exp = '{t[15:8], t[7:0], 8'h00, 8'h00, len[15:8], len[7:0], rows[r].unit,
              rows[r].fc, n[7:0]};
      for (int j = 0; j < n; j++) exp.push_back(dbyte(rows[r], j));
      if (rows[r].drop) exp.delete();
      mbtcp_master_model_inst.req(rows[r].fc, rows[r].st, rows[r].qty, rows[r].unit, r[0]);
      check(mbtcp_master_model_inst.hung, 1'b0);
      if (mbtcp_master_model_inst.hung) summarize();
      check(mbtcp_master_model_inst.dropped, rows[r].drop);
      check(16'(mbtcp_master_model_inst.rsp.size()), 16'(exp.size()));
      foreach (exp[i]) check(mbtcp_master_model_inst.rsp[i], exp[i]);
    end
    // Refusal of a bad protocol id and of a bad length field
    i_unit_addr = 8'h01;
    for (int k = 0; k < 2; k++)
    begin
      repeat (2) @(posedge i_clk_sys);
      #1;
      mbtcp_master_model_inst.proto   = k ? 16'h0000 : 16'h0001;
      mbtcp_master_model_inst.len_fld = k ? 16'h0007 : 16'h0006;
      mbtcp_master_model_inst.req(8'h04, 16'h9c40, 16'h0001, 8'h01, 1'b0);
      check(mbtcp_master_model_inst.dropped, 1'b1);
      check(16'(mbtcp_master_model_inst.rsp.size()), 16'h0000);
    end
    mbtcp_master_model_inst.len_fld = 16'h0006;
    // Reset between requests, then a read running past the input table
    i_sys_rst = 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1;
    check({o_rx_ready, o_tx_valid, o_tx_last, o_req_drop}, 16'h0008);
    i_sys_rst = 1'b0;
    repeat (2) @(posedge i_clk_sys);
    #1;
    t = mbtcp_master_model_inst.tid;
    mbtcp_master_model_inst.req(8'h02, 16'h00c4, 16'h0008, 8'h01, 1'b1);
    check(mbtcp_master_model_inst.hung, 1'b0);
    check(16'(mbtcp_master_model_inst.rsp.size()), 16'h000a);
    check({mbtcp_master_model_inst.rsp[0], mbtcp_master_model_inst.rsp[1]}, t);
    check(mbtcp_master_model_inst.rsp[9], 16'h0004);
    summarize();
  end
endmodule
